// >>> inc/spp_pkg.sv
package spp_pkg;
	// core clock and link rates
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_300 = 300;
	localparam int BAUD_1200 = 1200;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_19200 = 19200;
	localparam int DIV_W = 19;
	localparam int FRAME_BITS = 10;
	// terminal-ready modes
	localparam logic [1:0] DTR_ON = 2'h0;
	localparam logic [1:0] DTR_IBF = 2'h1;
	localparam logic [1:0] DTR_LIM = 2'h2;
	// rate selects
	localparam logic [2:0] SEL_300 = 3'h0;
	localparam logic [2:0] SEL_1200 = 3'h1;
	localparam logic [2:0] SEL_2400 = 3'h2;
	localparam logic [2:0] SEL_9600 = 3'h3;
	localparam logic [2:0] SEL_19200 = 3'h4;
	// parity modes
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	// fixed input-buffer thresholds and pacing characters
	localparam logic [4:0] RX_STOP_LVL = 5'h0c;
	localparam logic [4:0] RX_START_LVL = 5'h04;
	localparam logic [7:0] CHR_XON = 8'h11;
	localparam logic [7:0] CHR_XOFF = 8'h13;
	// query answers, ascii
	localparam logic [23:0] QRY_IBF = 24'h494246;
	localparam logic [23:0] QRY_ON = 24'h4f4e20;
	localparam logic [23:0] QRY_LIM = 24'h4c494d;
	localparam logic [31:0] QRY_XON = 32'h584f4e20;
	localparam logic [31:0] QRY_NONE = 32'h4e4f4e45;
	localparam logic [31:0] QRY_EVEN = 32'h4556454e;
	localparam logic [31:0] QRY_ODD = 32'h4f444420;
	// power-up settings
	localparam logic [1:0] RST_DTR = DTR_ON;
	localparam logic [2:0] RST_SEL = SEL_9600;
	localparam logic [1:0] RST_PAR = PAR_NONE;
endpackage : spp_pkg

// >>> tb/spp_far_end.sv
`timescale 1ns/1ps
module spp_far_end (
	// clock
	input wire logic core_clk,
	// pacing control and bit time
	input wire logic stall,
	input wire logic [15:0] bitCyc,
	// device pins
	input wire logic txd,
	input wire logic dtr,
	output logic rxd,
	output logic dsr,
	// decoded characters, stop bit on top
	output logic gotValid,
	output logic [8:0] gotData
);
	// set by the bench to send one frame with a low stop bit
	logic badStop = 1'b0;
	initial
	begin
		rxd = 1'b1;
		gotValid = 1'b0;
		gotData = '0;
	end
	assign dsr = !stall;
	task automatic sendChar(input logic [7:0] raw);
		logic [9:0] fr;
		fr = {!badStop, raw, 1'b0};
		while (dtr !== 1'b1)
			@(negedge core_clk);
		for (int i = 0; i < 10; i++)
		begin
			rxd = fr[i];
			repeat (bitCyc) @(negedge core_clk);
		end
		rxd = 1'b1;
	endtask : sendChar
	// sample device frames mid-bit
	always
	begin
		@(negedge core_clk);
		if (txd === 1'b0)
		begin
			repeat (bitCyc / 2) @(negedge core_clk);
			for (int i = 0; i < 9; i++)
			begin
				repeat (bitCyc) @(negedge core_clk);
				gotData[i] = txd;
			end
			gotValid = 1'b1;
			@(negedge core_clk);
			gotValid = 1'b0;
		end
	end
endmodule : spp_far_end

// >>> tb/spp_serial_port_bench.sv
`timescale 1ns/1ps
module spp_serial_port_bench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cfgCommit = 1'b0;
	logic [1:0] cfgDtrMode = '0;
	logic [2:0] cfgBaudSel = '0;
	logic cfgSoftPace = 1'b0;
	logic [1:0] cfgParity = '0;
	logic inLimit = 1'b0, txValid = 1'b0, rxReady = 1'b0, stall = 1'b0;
	logic [7:0] txData = '0;
	logic [15:0] bitCyc = 16'h0010;
	logic [23:0] qryDtrMode;
	logic [14:0] qryBaud;
	logic [31:0] qryPace, qryParity;
	logic txReady, rxValid, parityErr, frameErr, overrunErr;
	logic rxd, dsr, txd, dtr, gotValid;
	logic [7:0] rxData;
	logic [4:0] rxLevel;
	logic [8:0] gotData;
	logic [8:0] txExp[$];
	logic [7:0] rxExp[$];
	int num_errors = 0, n_checks = 0, cycles = 0, parErrs = 0;
	int frmErrs = 0, ovrErrs = 0;
	int seed = 32'h0d39fc05;
	int rates[5] = '{300, 1200, 2400, 9600, 19200};

	always #5 core_clk = !core_clk;

	spp_serial_port #(.CYC_300(16), .CYC_1200(16), .CYC_2400(16),
		.CYC_9600(16), .CYC_19200(8)) i_dut (.core_clk(core_clk),
		.rst_n(rst_n), .cfgCommit(cfgCommit), .cfgDtrMode(cfgDtrMode),
		.cfgBaudSel(cfgBaudSel), .cfgSoftPace(cfgSoftPace),
		.cfgParity(cfgParity), .qryDtrMode(qryDtrMode), .qryBaud(qryBaud),
		.qryPace(qryPace), .qryParity(qryParity), .inLimit(inLimit),
		.txValid(txValid), .txData(txData), .txReady(txReady),
		.rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
		.rxLevel(rxLevel), .parityErr(parityErr), .frameErr(frameErr),
		.overrunErr(overrunErr), .rxd(rxd), .dsr(dsr), .txd(txd), .dtr(dtr));

	spp_far_end i_far (.core_clk(core_clk), .stall(stall), .bitCyc(bitCyc),
		.txd(txd), .dtr(dtr), .rxd(rxd), .dsr(dsr), .gotValid(gotValid),
		.gotData(gotData));

	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	function automatic logic [7:0] framed(input logic [1:0] q, input logic [7:0] d);
		if (q == spp_pkg::PAR_NONE)
			return d;
		return {(q == spp_pkg::PAR_ODD) ^ (^d[6:0]), d[6:0]};
	endfunction : framed

	task automatic commit(input logic [1:0] m, input logic [2:0] s,
		input logic p, input logic [1:0] q);
		@(negedge core_clk);
		{cfgDtrMode, cfgBaudSel, cfgSoftPace, cfgParity} = {m, s, p, q};
		cfgCommit = 1'b1;
		if (q != 2'h3)
			bitCyc = (s == spp_pkg::SEL_19200) ? 16'h0008 : 16'h0010;
		@(negedge core_clk);
		cfgCommit = 1'b0;
		repeat (3) @(negedge core_clk);
	endtask : commit

	task automatic checkQry(input logic [1:0] m, input logic [2:0] s,
		input logic p, input logic [1:0] q);
		chk("qryDtrMode", m == 2'h1 ? spp_pkg::QRY_IBF : m == 2'h2 ?
			spp_pkg::QRY_LIM : spp_pkg::QRY_ON, qryDtrMode);
		chk("qryBaud", rates[s], qryBaud);
		chk("qryPace", p ? spp_pkg::QRY_XON : spp_pkg::QRY_NONE, qryPace);
		chk("qryParity", q == 2'h1 ? spp_pkg::QRY_EVEN : q == 2'h2 ?
			spp_pkg::QRY_ODD : spp_pkg::QRY_NONE, qryParity);
	endtask : checkQry

	task automatic sendTx(input logic [1:0] q, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge core_clk);
		txExp.push_back({1'b1, framed(q, d)});
		txValid = 1'b1;
		txData = d;
		while (txReady !== 1'b1 && n < 4000)
		begin
			@(negedge core_clk);
			n++;
		end
		@(negedge core_clk);
		txValid = 1'b0;
	endtask : sendTx

	task automatic waitTx;
		int n;
		n = 0;
		while (txExp.size() != 0 && n < 4000)
		begin
			@(negedge core_clk);
			n++;
		end
		chk("tx queue left", 0, txExp.size());
		repeat (bitCyc) @(negedge core_clk);
	endtask : waitTx

	task automatic sendRx(input logic [7:0] raw, input logic [7:0] e);
		rxExp.push_back(e);
		i_far.sendChar(raw);
	endtask : sendRx

	task automatic popRx(input int k);
		repeat (k)
		begin
			@(negedge core_clk);
			rxReady = 1'b1;
			@(negedge core_clk);
			rxReady = 1'b0;
		end
	endtask : popRx

	// scoreboard on both data paths
	always @(posedge core_clk)
	begin
		cycles++;
		if (rxValid === 1'b1 && rxReady)
			chk("rxData", rxExp.pop_front(), rxData);
		if (gotValid)
			chk("txd char", txExp.pop_front(), gotData);
		if (parityErr === 1'b1)
			parErrs++;
		if (frameErr === 1'b1)
			frmErrs++;
		if (overrunErr === 1'b1)
			ovrErrs++;
		if (cycles == 40000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	initial
	begin
		logic [7:0] b;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (5) @(negedge core_clk);
		for (int i = 0; i < 5; i++)
		begin
			commit(2'(i % 3), 3'(i), 1'(i), 2'(i % 3));
			checkQry(2'(i % 3), 3'(i), 1'(i), 2'(i % 3));
		end
		commit(2'h0, 3'h3, 1'b1, 2'h3);
		checkQry(2'h1, 3'h4, 1'b0, 2'h1);
		// transmit framing per parity, last pass at the top rate
		for (int p = 0; p < 4; p++)
		begin
			logic [1:0] q;
			q = (p == 3) ? 2'h0 : 2'(p);
			commit(2'h0, p == 3 ? 3'h4 : 3'h3, 1'b0, q);
			repeat (3) sendTx(q, 8'($random(seed)));
			waitTx();
		end
		// receive plain, then even parity with one bad parity bit
		commit(2'h0, 3'h3, 1'b0, 2'h0);
		repeat (3)
		begin
			b = 8'($random(seed));
			sendRx(b, b);
		end
		commit(2'h0, 3'h3, 1'b0, 2'h1);
		for (int k = 0; k < 4; k++)
		begin
			b = 8'($random(seed));
			sendRx(framed(k == 3 ? 2'h2 : 2'h1, b), {1'b0, b[6:0]});
		end
		repeat (5) @(negedge core_clk);
		chk("parity errors", 1, parErrs);
		popRx(7);
		// low stop bit drops the byte, then overfill the buffer
		commit(2'h0, 3'h3, 1'b0, 2'h0);
		i_far.badStop = 1'b1;
		i_far.sendChar(8'h5a);
		i_far.badStop = 1'b0;
		repeat (40) @(negedge core_clk);
		chk("frame errors", 1, frmErrs);
		chk("rxLevel bad stop", 0, rxLevel);
		for (int k = 0; k < 17; k++)
		begin
			b = 8'($random(seed));
			if (k < 16)
				rxExp.push_back(b);
			i_far.sendChar(b);
		end
		repeat (5) @(negedge core_clk);
		chk("overrun errors", 1, ovrErrs);
		chk("rxLevel full", 16, rxLevel);
		popRx(16);
		// dsr low halts sending under buffer pacing
		commit(2'h1, 3'h3, 1'b0, 2'h0);
		stall = 1'b1;
		repeat (6) @(negedge core_clk);
		chk("txReady dsr low", 0, txReady);
		stall = 1'b0;
		repeat (6) @(negedge core_clk);
		chk("txReady dsr high", 1, txReady);
		// fill to the stop level with software pacing, then drain
		commit(2'h1, 3'h3, 1'b1, 2'h0);
		txExp.push_back({1'b1, spp_pkg::CHR_XOFF});
		for (int k = 0; k < 12; k++)
		begin
			if (k == 11)
				chk("dtr below stop", 1, dtr);
			b = 8'($random(seed));
			if (b == spp_pkg::CHR_XON || b == spp_pkg::CHR_XOFF)
				b ^= 8'h80;
			sendRx(b, b);
		end
		repeat (3) @(negedge core_clk);
		chk("dtr at stop", 0, dtr);
		chk("rxLevel", 12, rxLevel);
		chk("txReady dtr low", 0, txReady);
		commit(2'h0, 3'h3, 1'b1, 2'h0);
		chk("dtr always on", 1, dtr);
		commit(2'h1, 3'h3, 1'b1, 2'h0);
		chk("dtr back to pacing", 0, dtr);
		popRx(7);
		repeat (3) @(negedge core_clk);
		chk("dtr above start", 0, dtr);
		txExp.push_back({1'b1, spp_pkg::CHR_XON});
		popRx(1);
		repeat (3) @(negedge core_clk);
		chk("dtr at start", 1, dtr);
		popRx(4);
		waitTx();
		// remote pause and resume
		commit(2'h0, 3'h3, 1'b1, 2'h0);
		i_far.sendChar(spp_pkg::CHR_XOFF);
		repeat (4) @(negedge core_clk);
		chk("txReady after pause", 0, txReady);
		chk("rxLevel control", 0, rxLevel);
		i_far.sendChar(spp_pkg::CHR_XON);
		repeat (4) @(negedge core_clk);
		chk("txReady after resume", 1, txReady);
		// limit indication follows the measurement
		commit(2'h2, 3'h3, 1'b0, 2'h0);
		repeat (40)
		begin
			inLimit = 1'($random(seed));
			@(negedge core_clk);
			chk("dtr limit", inLimit, dtr);
		end
		// settings survive a reset
		commit(2'h2, 3'h2, 1'b1, 2'h2);
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (5) @(negedge core_clk);
		checkQry(2'h2, 3'h2, 1'b1, 2'h2);
		report_and_stop();
	end
endmodule : spp_serial_port_bench

// >>> verilog/spp_fifo.sv
`timescale 1ns/1ps
module spp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int LW = $clog2(DEPTH + 1)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// fill side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// drain side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady,
	// fill level
	output logic [LW-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [LW-1:0] cnt_q;
	wire doPush = inValid && inReady;
	wire doPop = outValid && outReady;
	assign inReady = cnt_q != LW'(DEPTH);
	assign outValid = cnt_q != '0;
	assign outData = mem[rdPtr_q];
	assign level = cnt_q;
	always_ff @(posedge clk)
	begin
		if (doPush)
			mem[wrPtr_q] <= inData;
	end
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			if (doPop)
				rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			cnt_q <= cnt_q + LW'(doPush) - LW'(doPop);
		end
	end
endmodule : spp_fifo

// >>> verilog/spp_serial_port.sv
`timescale 1ns/1ps
module spp_serial_port #(
	parameter int FIFO_DEPTH = 16,
	parameter int CYC_300 = spp_pkg::CLK_HZ / spp_pkg::BAUD_300,
	parameter int CYC_1200 = spp_pkg::CLK_HZ / spp_pkg::BAUD_1200,
	parameter int CYC_2400 = spp_pkg::CLK_HZ / spp_pkg::BAUD_2400,
	parameter int CYC_9600 = spp_pkg::CLK_HZ / spp_pkg::BAUD_9600,
	parameter int CYC_19200 = spp_pkg::CLK_HZ / spp_pkg::BAUD_19200
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// settings, taken on the terminator strobe
	input wire logic cfgCommit,
	input wire logic [1:0] cfgDtrMode,
	input wire logic [2:0] cfgBaudSel,
	input wire logic cfgSoftPace,
	input wire logic [1:0] cfgParity,
	// setting queries
	output logic [23:0] qryDtrMode,
	output logic [14:0] qryBaud,
	output logic [31:0] qryPace,
	output logic [31:0] qryParity,
	// measurement state
	input wire logic inLimit,
	// transmit characters
	input wire logic txValid,
	input wire logic [7:0] txData,
	output logic txReady,
	// received characters
	output logic rxValid,
	output logic [7:0] rxData,
	input wire logic rxReady,
	output logic [4:0] rxLevel,
	output logic parityErr,
	output logic frameErr,
	output logic overrunErr,
	// pins
	input wire logic rxd,
	input wire logic dsr,
	output logic txd,
	output logic dtr
);
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PAR = 5'h08,
		RX_STOP = 5'h10
	} spp_rx_t;

	logic [1:0] rstPipe_q;
	wire rstN = rstPipe_q[1];
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rstPipe_q <= '0;
		else
			rstPipe_q <= {rstPipe_q[0], 1'b1};
	end

	// settings: no reset, held like non-volatile storage
	logic [1:0] dtrMode_q = spp_pkg::RST_DTR;
	logic [2:0] baudSel_q = spp_pkg::RST_SEL;
	logic softPace_q = 1'b0;
	logic [1:0] parity_q = spp_pkg::RST_PAR;
	wire cfgOk = cfgDtrMode != 2'h3 && cfgBaudSel <= spp_pkg::SEL_19200
		&& cfgParity != 2'h3;
	always_ff @(posedge core_clk)
	begin
		if (cfgCommit && cfgOk)
		begin
			dtrMode_q <= cfgDtrMode;
			baudSel_q <= cfgBaudSel;
			softPace_q <= cfgSoftPace;
			parity_q <= cfgParity;
		end
	end

	function automatic logic [spp_pkg::DIV_W-1:0] divOf(input logic [2:0] s);
		case (s)
			spp_pkg::SEL_300: divOf = spp_pkg::DIV_W'(CYC_300);
			spp_pkg::SEL_1200: divOf = spp_pkg::DIV_W'(CYC_1200);
			spp_pkg::SEL_2400: divOf = spp_pkg::DIV_W'(CYC_2400);
			spp_pkg::SEL_9600: divOf = spp_pkg::DIV_W'(CYC_9600);
			default: divOf = spp_pkg::DIV_W'(CYC_19200);
		endcase
	endfunction : divOf
	wire [spp_pkg::DIV_W-1:0] bitDiv = divOf(baudSel_q);

	// query answers
	wire [23:0] dtrQ = (dtrMode_q == spp_pkg::DTR_IBF) ? spp_pkg::QRY_IBF :
		(dtrMode_q == spp_pkg::DTR_LIM) ? spp_pkg::QRY_LIM : spp_pkg::QRY_ON;
	wire [14:0] baudQ = (baudSel_q == spp_pkg::SEL_300) ? 15'(spp_pkg::BAUD_300) :
		(baudSel_q == spp_pkg::SEL_1200) ? 15'(spp_pkg::BAUD_1200) :
		(baudSel_q == spp_pkg::SEL_2400) ? 15'(spp_pkg::BAUD_2400) :
		(baudSel_q == spp_pkg::SEL_9600) ? 15'(spp_pkg::BAUD_9600) :
		15'(spp_pkg::BAUD_19200);
	wire [31:0] paceQ = softPace_q ? spp_pkg::QRY_XON : spp_pkg::QRY_NONE;
	wire [31:0] parQ = (parity_q == spp_pkg::PAR_EVEN) ? spp_pkg::QRY_EVEN :
		(parity_q == spp_pkg::PAR_ODD) ? spp_pkg::QRY_ODD : spp_pkg::QRY_NONE;
	always_ff @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			qryDtrMode <= spp_pkg::QRY_ON;
			qryBaud <= '0;
			qryPace <= spp_pkg::QRY_NONE;
			qryParity <= spp_pkg::QRY_NONE;
		end
		else
		begin
			qryDtrMode <= dtrQ;
			qryBaud <= baudQ;
			qryPace <= paceQ;
			qryParity <= parQ;
		end
	end

	// pin inputs: three stages, change taken when stages two and three agree
	logic [2:0] rxdS_q;
	logic [2:0] dsrS_q;
	logic rxdF_q;
	logic dsrF_q;
	always_ff @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			rxdS_q <= '1;
			dsrS_q <= '0;
			rxdF_q <= 1'b1;
			dsrF_q <= 1'b0;
		end
		else
		begin
			rxdS_q <= {rxdS_q[1:0], rxd};
			dsrS_q <= {dsrS_q[1:0], dsr};
			if (rxdS_q[1] == rxdS_q[2])
				rxdF_q <= rxdS_q[2];
			if (dsrS_q[1] == dsrS_q[2])
				dsrF_q <= dsrS_q[2];
		end
	end

	// receiver
	spp_rx_t rxSt_q;
	spp_rx_t rxSt_d;
	logic [spp_pkg::DIV_W-1:0] rxCnt_q;
	logic [2:0] rxBit_q;
	logic [7:0] rxSh_q;
	logic rxPar_q;
	wire parOn = parity_q != spp_pkg::PAR_NONE;
	wire [2:0] lastBit = parOn ? 3'h6 : 3'h7;
	wire rxTick = rxCnt_q == '0;
	wire [7:0] rxByte = parOn ? {1'b0, rxSh_q[6:0]} : rxSh_q;
	wire parBad = parOn && ((^rxSh_q[6:0] ^ rxPar_q)
		!= (parity_q == spp_pkg::PAR_ODD));
	wire stopSeen = rxSt_q == RX_STOP && rxTick;
	wire isXon = softPace_q && rxByte == spp_pkg::CHR_XON;
	wire isXoff = softPace_q && rxByte == spp_pkg::CHR_XOFF;
	wire rxDone = stopSeen && rxdF_q;
	wire rxPush = rxDone && !isXon && !isXoff;
	wire fifoInReady;
	always_comb
	begin
		rxSt_d = rxSt_q;
		case (rxSt_q)
			RX_IDLE:
				if (!rxdF_q)
					rxSt_d = RX_START;
			RX_START:
				if (rxTick)
					rxSt_d = rxdF_q ? RX_IDLE : RX_DATA;
			RX_DATA:
				if (rxTick && rxBit_q == lastBit)
					rxSt_d = parOn ? RX_PAR : RX_STOP;
			RX_PAR:
				if (rxTick)
					rxSt_d = RX_STOP;
			RX_STOP:
				if (rxTick)
					rxSt_d = RX_IDLE;
			default:
				rxSt_d = RX_IDLE;
		endcase
	end
	always_ff @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			rxSt_q <= RX_IDLE;
			rxCnt_q <= '0;
			rxBit_q <= '0;
			rxSh_q <= '0;
			rxPar_q <= 1'b0;
		end
		else
		begin
			rxSt_q <= rxSt_d;
			if (rxSt_q == RX_IDLE)
				rxCnt_q <= bitDiv >> 1;
			else
				rxCnt_q <= rxTick ? bitDiv - 1'b1 : rxCnt_q - 1'b1;
			if (rxSt_q == RX_START)
				rxBit_q <= '0;
			if (rxSt_q == RX_DATA && rxTick)
			begin
				rxSh_q[rxBit_q] <= rxdF_q;
				rxBit_q <= rxBit_q + 1'b1;
			end
			if (rxSt_q == RX_START)
				rxSh_q <= '0;
			if (rxSt_q == RX_PAR && rxTick)
				rxPar_q <= rxdF_q;
		end
	end
	always_ff @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			parityErr <= 1'b0;
			frameErr <= 1'b0;
			overrunErr <= 1'b0;
		end
		else
		begin
			parityErr <= rxDone && parBad;
			frameErr <= stopSeen && !rxdF_q;
			overrunErr <= rxPush && !fifoInReady;
		end
	end

	// input buffer
	logic [4:0] level;
	spp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .LW(5)) rxFifo (
		.clk(core_clk),
		.rstN(rstN),
		.inValid(rxPush),
		.inData(rxByte),
		.inReady(fifoInReady),
		.outValid(rxValid),
		.outData(rxData),
		.outReady(rxReady),
		.level(level)
	);
	assign rxLevel = level;

	// pacing state
	wire atStop = level >= spp_pkg::RX_STOP_LVL;
	wire atStart = level <= spp_pkg::RX_START_LVL;
	logic dtrIbf_q;
	logic farXoff_q;
	logic xoffSent_q;
	wire ibfMode = dtrMode_q == spp_pkg::DTR_IBF;
	wire needXoff = softPace_q && atStop && !xoffSent_q;
	wire needXon = softPace_q && atStart && xoffSent_q;
	wire ctrlWant = needXoff || needXon;
	wire halt = (ibfMode && (!dsrF_q || !dtrIbf_q))
		|| (softPace_q && farXoff_q);
	wire txIdle;
	wire txGo = ctrlWant || (txValid && !halt);
	wire [7:0] txByte = needXoff ? spp_pkg::CHR_XOFF :
		needXon ? spp_pkg::CHR_XON : txData;
	assign txReady = txIdle && !ctrlWant && !halt;
	wire dtrD = (dtrMode_q == spp_pkg::DTR_IBF) ? dtrIbf_q :
		(dtrMode_q == spp_pkg::DTR_LIM) ? inLimit : 1'b1;
	always_ff @(posedge core_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			dtrIbf_q <= 1'b1;
			farXoff_q <= 1'b0;
			xoffSent_q <= 1'b0;
			dtr <= 1'b1;
		end
		else
		begin
			if (atStop)
				dtrIbf_q <= 1'b0;
			else if (atStart)
				dtrIbf_q <= 1'b1;
			if (!softPace_q)
				farXoff_q <= 1'b0;
			else if (rxDone && isXoff)
				farXoff_q <= 1'b1;
			else if (rxDone && isXon)
				farXoff_q <= 1'b0;
			if (!softPace_q)
				xoffSent_q <= 1'b0;
			else if (txIdle && ctrlWant)
				xoffSent_q <= needXoff;
			dtr <= dtrD;
		end
	end

	spp_tx txUnit (
		.clk(core_clk),
		.rstN(rstN),
		.bitDiv(bitDiv),
		.parMode(parity_q),
		.valid(txGo),
		.data(txByte),
		.ready(txIdle),
		.txd(txd)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstN);
	chk_dtr_always_on: assert property (
		(dtrMode_q == spp_pkg::DTR_ON) ##1 (dtrMode_q == spp_pkg::DTR_ON)
		|-> dtr) else $error("dtr low in always-on mode");
	chk_dtr_stop_level: assert property (
		ibfMode && atStop ##1 ibfMode |-> ##1 !dtr)
		else $error("dtr not dropped at stop level");
	chk_dtr_start_level: assert property (
		ibfMode && !dtrIbf_q && atStart ##1 ibfMode |-> ##1 dtr)
		else $error("dtr not raised at start level");
	chk_halt_on_dsr: assert property (
		ibfMode && !dsrF_q |-> !txReady)
		else $error("transmit accepted while dsr low");
	chk_dtr_limit_follow: assert property (
		(dtrMode_q == spp_pkg::DTR_LIM) ##1 (dtrMode_q == spp_pkg::DTR_LIM)
		|-> dtr == $past(inLimit)) else $error("dtr does not follow limit");
	chk_baud_query: assert property (
		(baudSel_q == spp_pkg::SEL_300) ##1 (baudSel_q == spp_pkg::SEL_300)
		|-> qryBaud == 15'(spp_pkg::BAUD_300) && bitDiv == CYC_300)
		else $error("rate 300 wrongly reported");
	chk_settings_hold: assert property (
		!cfgCommit |=> $stable(dtrMode_q) && $stable(baudSel_q)
		&& $stable(parity_q) && $stable(softPace_q))
		else $error("setting changed without commit");
	chk_setting_apply: assert property (
		cfgCommit && cfgOk |=> dtrMode_q == $past(cfgDtrMode)
		&& parity_q == $past(cfgParity))
		else $error("setting not applied on commit");
	chk_xoff_halts: assert property (
		rxDone && isXoff |=> !txReady)
		else $error("transmit accepted after xoff");
	chk_parity_flag: assert property (
		rxDone && parBad |=> parityErr)
		else $error("parity mismatch not flagged");
	cov_rx_char: cover property (rxPush && fifoInReady);
	cov_dtr_drop: cover property (ibfMode && $fell(dtr));
	cov_xoff_sent: cover property ($rose(xoffSent_q));
	cov_parity_bad: cover property (parityErr);
endmodule : spp_serial_port

// >>> verilog/spp_tx.sv
`timescale 1ns/1ps
module spp_tx (
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// settings
	input wire logic [spp_pkg::DIV_W-1:0] bitDiv,
	input wire logic [1:0] parMode,
	// character in
	input wire logic valid,
	input wire logic [7:0] data,
	output logic ready,
	// line
	output logic txd
);
	logic [spp_pkg::FRAME_BITS-1:0] sh_q;
	logic [3:0] left_q;
	logic [spp_pkg::DIV_W-1:0] cnt_q;
	wire parOn = parMode != spp_pkg::PAR_NONE;
	wire parBit = (parMode == spp_pkg::PAR_ODD) ? ~^data[6:0] : ^data[6:0];
	// one start, one stop, always ten bits
	wire [spp_pkg::FRAME_BITS-1:0] frame = parOn ?
		{1'b1, parBit, data[6:0], 1'b0} : {1'b1, data, 1'b0};
	wire bitEnd = cnt_q == '0;
	assign ready = left_q == '0;
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			sh_q <= '1;
			left_q <= '0;
			cnt_q <= '0;
			txd <= 1'b1;
		end
		else if (ready && valid)
		begin
			sh_q <= frame;
			left_q <= 4'(spp_pkg::FRAME_BITS);
			cnt_q <= bitDiv - 1'b1;
			txd <= 1'b0;
		end
		else if (!ready)
		begin
			cnt_q <= bitEnd ? bitDiv - 1'b1 : cnt_q - 1'b1;
			if (bitEnd)
			begin
				sh_q <= {1'b1, sh_q[spp_pkg::FRAME_BITS-1:1]};
				left_q <= left_q - 1'b1;
				txd <= (left_q == 4'h1) ? 1'b1 : sh_q[1];
			end
		end
	end
endmodule : spp_tx
